// file: hw/spf_ctrl.sv
// Functional notes
// RULE1 - Software clears both FIFOs after setting duplex mode and FIFO use.
// RULE2 - Writing one to transmit clear bit 7 empties FIFO, level 000.
// RULE3 - Condition bit 0: transmit interrupt only when fill hits threshold.
// RULE4 - Condition bit 1: also interrupt when fill falls short after a take.
// RULE5 - Threshold 00/01/10/11 is 0..3 bytes; full duplex uses bit 0 only.
// RULE6 - Software reprograms transmit configuration after stopping channel.
// RULE7 - Software reprograms transmit setup after wake if idle run is off.
// RULE8 - Receive status bit 7 reports overrun, read only.
// RULE9 - Reading received data from the data buffer clears the overrun flag.
// RULE10 - Receive status bits 2-0 report receive fill, 000 to 100.
// RULE11 - Unused bits of both registers read zero; all fields reset zero except transmit underrun, which resets one.
// RULE12 - Writing receive clear empties receive FIFO and resets its pointers.
// RULE13 - Transmit underrun resets to one, clears on a data buffer write.
// RULE14 - In nine-bit mode the FIFOs are not used, single byte only.
// RULE15 - A byte arriving with receive FIFO at capacity sets overrun.
`timescale 1ns/1ps
`include "spf_cfg.svh"
module spf_ctrl #(
  parameter int DEPTH  = 4,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // Serial shift logic side.
  output logic [7:0]             TX_DATA,
  output logic                   TX_VALID,
  input  wire logic              TX_TAKE,
  input  wire logic [7:0]        RX_DATA,
  input  wire logic              RX_VALID,
  // Interrupt.
  output logic                   IRQ
);
  spf_fifo_if #(.W(8), .CW(3)) txf ();
  spf_fifo_if #(.W(8), .CW(3)) rxf ();

  spf_fifo #(.W(8), .D(DEPTH)) u_tx (
    .clk   (CLK),
    .rst_b (RST_B),
    .f     (txf)
  );
  spf_fifo #(.W(8), .D(DEPTH)) u_rx (
    .clk   (CLK),
    .rst_b (RST_B),
    .f     (rxf)
  );

  // RULE5 threshold decode
  // Threshold in bytes; full duplex only looks at the low bit.
  function automatic spf_pkg::spf_lvl_t tx_level(input logic [1:0] tx_irq_threshold,
                                                 input logic fd);
    tx_level = fd ? {2'h0, tx_irq_threshold[0]} : {1'h0, tx_irq_threshold};
  endfunction

  // Bus state.
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_byte_r;
  logic              w_lane_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  // Block state.
  logic              tx_irq_condition_select_r;
  logic [1:0]        til_r;
  logic              en_r;
  logic              fd_r;
  logic              nine_r;
  logic              ror_r;
  logic              tur_r;
  logic [2:0]        ist_r;
  logic [2:0]        imk_r;
  logic              irq_r;
  logic [7:0]        txd_r;
  logic              txv_r;

  // Handshake decode.
  wire aw_take = AWVALID & awready_r;
  wire w_take  = WVALID & wready_r;
  wire wr_do   = aw_hold_r & w_hold_r & ~bvalid_r;
  wire rd_do   = ARVALID & arready_r;
  wire aw_nxt  = aw_take | (aw_hold_r & ~wr_do);
  wire w_nxt   = w_take | (w_hold_r & ~wr_do);
  wire rv_nxt  = rd_do | (rvalid_r & ~RREADY);

  // Write address decode; only byte lane 0 carries fields.
  wire wr_lo   = wr_do & w_lane_r;
  wire hit_db  = aw_addr_r == `SPF_OFS_DBUF;
  wire hit_tfc = aw_addr_r == `SPF_OFS_TFC;
  wire hit_ctl = aw_addr_r == `SPF_OFS_CTL;
  wire hit_ist = aw_addr_r == `SPF_OFS_IST;
  wire hit_imk = aw_addr_r == `SPF_OFS_IMK;
  wire wr_ok   = hit_db | hit_tfc | hit_ctl | hit_ist | hit_imk |
                 (aw_addr_r == `SPF_OFS_RST) |
                 (aw_addr_r == `SPF_OFS_TST);
  wire wr_db   = wr_lo & hit_db;
  wire wr_tfc  = wr_lo & hit_tfc;
  wire wr_ctl  = wr_lo & hit_ctl;

  // Read address decode.
  wire rd_db   = rd_do & (ARADDR == `SPF_OFS_DBUF);
  wire rd_ok   = (ARADDR == `SPF_OFS_DBUF) | (ARADDR == `SPF_OFS_TFC) |
                 (ARADDR == `SPF_OFS_RST) | (ARADDR == `SPF_OFS_TST) |
                 (ARADDR == `SPF_OFS_CTL) | (ARADDR == `SPF_OFS_IST) |
                 (ARADDR == `SPF_OFS_IMK);

  // RULE14 nine-bit capacity
  wire [2:0] cap = (~en_r | nine_r) ? `SPF_CAP_ONE :
                   fd_r ? `SPF_CAP_FULL : `SPF_CAP_HALF;

  // RULE2 transmit clear
  wire tx_clr = wr_tfc & w_byte_r[`SPF_B_CLR];
  // RULE12 receive clear
  wire rx_clr = wr_ctl & w_byte_r[`SPF_B_RCLR];

  // Output stage refills when empty or when its byte is taken.
  wire tx_load = ~txf.empty & ~tx_clr & (~txv_r | TX_TAKE);
  wire [2:0] tx_after = txf.count - 3'h1;
  wire spf_pkg::spf_lvl_t lvl = tx_level(til_r, fd_r);

  // RULE3 threshold reached
  wire tx_hit = tx_load & (tx_after == lvl);
  // RULE4 threshold out of reach
  wire tx_short = tx_load & tx_irq_condition_select_r & (tx_after < lvl);
  wire tx_evt = tx_hit | tx_short;

  // RULE15 overrun on full
  wire ovr_set = RX_VALID & rxf.full & ~rx_clr;
  // Underrun: the shift logic drained the stage with nothing behind it.
  wire tur_set = TX_TAKE & txv_r & txf.empty;

  wire [2:0] ev  = {tur_set, ovr_set, tx_evt};
  wire [2:0] w1c = (wr_lo & hit_ist) ? w_byte_r[2:0] : 3'h0;
  // Set beats a clear arriving in the same cycle.
  wire [2:0] ist_nxt = (ist_r & ~w1c) | ev;

  // FIFO hookups.
  assign txf.push  = wr_db;
  assign txf.wdata = w_byte_r;
  assign txf.pop   = tx_load;
  assign txf.clear = tx_clr;
  assign txf.cap   = cap;
  assign rxf.push  = RX_VALID & ~rx_clr;
  assign rxf.wdata = RX_DATA;
  assign rxf.pop   = rd_db;
  assign rxf.clear = rx_clr;
  assign rxf.cap   = cap;

  // Read mux; unused bits stay zero.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    unique case (ARADDR)
      `SPF_OFS_DBUF: rd_val[7:0] = rxf.empty ? 8'h00 : rxf.head;
      `SPF_OFS_TFC: begin
        rd_val[`SPF_B_TX_IRQ_CONDITION_SELECT] = tx_irq_condition_select_r;
        rd_val[1:0]         = til_r;
      end
      // RULE8 overrun bit
      `SPF_OFS_RST: begin
        rd_val[`SPF_B_FLAG] = ror_r;
        // RULE10 receive fill
        rd_val[2:0]         = rxf.count;
      end
      `SPF_OFS_TST: begin
        rd_val[`SPF_B_FLAG] = tur_r;
        rd_val[2:0]         = txf.count;
      end
      `SPF_OFS_CTL: rd_val[2:0] = {nine_r, fd_r, en_r};
      `SPF_OFS_IST: rd_val[2:0] = ist_r;
      `SPF_OFS_IMK: rd_val[2:0] = imk_r;
      default: rd_val = 32'h0;
    endcase
  end

  // Write side of the bus slave.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= spf_pkg::SPF_OKAY;
    end else begin
      aw_hold_r <= aw_nxt;
      w_hold_r  <= w_nxt;
      awready_r <= ~aw_nxt;
      wready_r  <= ~w_nxt;
      bvalid_r  <= wr_do | (bvalid_r & ~BREADY);
      if (wr_do) begin
        bresp_r <= wr_ok ? spf_pkg::SPF_OKAY : spf_pkg::SPF_SLVERR;
      end
    end
  end

  // Payload latches need no reset.
  always_ff @(posedge CLK) begin
    if (aw_take) begin
      aw_addr_r <= AWADDR;
    end
    if (w_take) begin
      w_byte_r <= WDATA[7:0];
      w_lane_r <= WSTRB[0];
    end
  end

  // Read side of the bus slave.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= spf_pkg::SPF_OKAY;
    end else begin
      arready_r <= ~rv_nxt;
      rvalid_r  <= rv_nxt;
      if (rd_do) begin
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? spf_pkg::SPF_OKAY : spf_pkg::SPF_SLVERR;
      end
    end
  end

  // RULE11 reset to zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {tx_irq_condition_select_r, til_r}      <= `SPF_RST_TFC;
      {nine_r, fd_r, en_r} <= `SPF_RST_CTL;
      imk_r                <= `SPF_RST_IRQ;
    end else begin
      if (wr_tfc) begin
        {tx_irq_condition_select_r, til_r} <= {w_byte_r[`SPF_B_TX_IRQ_CONDITION_SELECT], w_byte_r[1:0]};
      end
      if (wr_ctl) begin
        en_r   <= w_byte_r[`SPF_B_EN];
        fd_r   <= w_byte_r[`SPF_B_FD];
        nine_r <= w_byte_r[`SPF_B_NINE];
      end
      if (wr_lo & hit_imk) begin
        imk_r <= w_byte_r[2:0];
      end
    end
  end

  // Flags: hardware set always wins over the clearing access.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ror_r <= 1'b0;
      tur_r <= `SPF_RST_TUR;
      ist_r <= `SPF_RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      // RULE9 read clears overrun
      ror_r <= ovr_set | (ror_r & ~rd_db);
      // RULE13 write clears underrun
      tur_r <= tur_set | (tur_r & ~wr_db);
      ist_r <= ist_nxt;
      irq_r <= |(ist_nxt & imk_r);
    end
  end

  // Transmit output stage toward the shift logic.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      txd_r <= 8'h00;
      txv_r <= 1'b0;
    end else begin
      txv_r <= tx_load | (txv_r & ~TX_TAKE);
      if (tx_load) begin
        txd_r <= txf.head;
      end
    end
  end

  assign AWREADY  = awready_r;
  assign WREADY   = wready_r;
  assign BVALID   = bvalid_r;
  assign BRESP    = bresp_r;
  assign ARREADY  = arready_r;
  assign RVALID   = rvalid_r;
  assign RDATA    = rdata_r;
  assign RRESP    = rresp_r;
  assign TX_DATA  = txd_r;
  assign TX_VALID = txv_r;
  assign IRQ      = irq_r;

  // Checks of the block against its own behaviour.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  tx_clear_empty_a: assert property ( // RULE2
    tx_clr |=> txf.count == 3'h0 ##1 txf.count <= 3'h1)
    else $error("transmit clear did not empty the FIFO");
  tx_level_irq_a: assert property ( // RULE3
    $rose(ist_r[`SPF_I_TX]) |-> $past(tx_evt))
    else $error("transmit status rose without a threshold event");
  tx_short_irq_a: assert property ( // RULE4
    (tx_load & tx_irq_condition_select_r & (tx_after < lvl)) |=> ist_r[`SPF_I_TX])
    else $error("short fill did not raise transmit status");
  til_full_duplex_a: assert property ( // RULE5
    fd_r |-> (lvl == {2'h0, til_r[0]}))
    else $error("full duplex threshold decoded wrongly");
  rx_overrun_set_a: assert property ( // RULE15
    (RX_VALID & rxf.full & ~rx_clr) |=> ror_r ##0 ist_r[`SPF_I_OVR])
    else $error("byte into full receive FIFO not flagged");
  rx_overrun_clr_a: assert property ( // RULE9
    (rd_db & ~ovr_set) |=> !ror_r)
    else $error("data read did not clear overrun");
  rx_status_read_a: assert property ( // RULE10
    (rd_do & (ARADDR == `SPF_OFS_RST)) |=> RVALID &&
      RDATA[2:0] == $past(rxf.count) && RDATA[7] == $past(ror_r))
    else $error("receive status read returned wrong fill");
  rx_status_zero_a: assert property ( // RULE11
    (RVALID & $past(rd_do) & ($past(ARADDR) == `SPF_OFS_RST))
      |-> RDATA[31:8] == 24'h0 && RDATA[6:3] == 4'h0)
    else $error("receive status unused bits not zero");
  rx_clear_empty_a: assert property ( // RULE12
    rx_clr |=> rxf.count == 3'h0)
    else $error("receive clear did not empty the FIFO");
  tx_underrun_clr_a: assert property ( // RULE13
    (wr_db & ~tur_set) |=> !tur_r)
    else $error("data write did not clear underrun");
  nine_bit_cap_a: assert property ( // RULE14
    nine_r |=> (rxf.count <= 3'h1 || rxf.count <= $past(rxf.count)) &&
      (txf.count <= 3'h1 || txf.count <= $past(txf.count)))
    else $error("FIFO grew beyond one byte in nine-bit mode");
endmodule

// file: hw/spf_cfg.svh
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH
// Register byte offsets.
`define SPF_OFS_DBUF 8'h00
`define SPF_OFS_TFC  8'h04
`define SPF_OFS_RST  8'h08
`define SPF_OFS_TST  8'h0c
`define SPF_OFS_CTL  8'h10
`define SPF_OFS_IST  8'h14
`define SPF_OFS_IMK  8'h18
// Field positions.
`define SPF_B_CLR    7
`define SPF_B_FLAG   7
`define SPF_B_TX_IRQ_CONDITION_SELECT   6
`define SPF_B_EN     0
`define SPF_B_FD     1
`define SPF_B_NINE   2
`define SPF_B_RCLR   3
`define SPF_I_TX     0
`define SPF_I_OVR    1
`define SPF_I_TUR    2
// Reset values.
`define SPF_RST_TFC  3'h0
`define SPF_RST_CTL  3'h0
`define SPF_RST_TUR  1'b1
`define SPF_RST_IRQ  3'h0
// Usable depth per mode.
`define SPF_CAP_HALF 3'h4
`define SPF_CAP_FULL 3'h2
`define SPF_CAP_ONE  3'h1
`endif

// file: hw/spf_pkg.sv
package spf_pkg;
  typedef logic [7:0] spf_byte_t;
  typedef logic [2:0] spf_lvl_t;
  typedef enum logic [1:0] {
    SPF_OKAY   = 2'h0,
    SPF_SLVERR = 2'h2
  } spf_resp_t;
endpackage

// file: hw/spf_fifo_if.sv
`timescale 1ns/1ps
interface spf_fifo_if #(parameter int W = 8, parameter int CW = 3);
  logic          push;
  logic          pop;
  logic          clear;
  logic [W-1:0]  wdata;
  logic [W-1:0]  head;
  logic [CW-1:0] cap;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;
  modport ctl (output push, pop, clear, wdata, cap,
               input head, count, full, empty);
  modport mem (input push, pop, clear, wdata, cap,
               output head, count, full, empty);
endinterface

// file: hw/spf_fifo.sv
`timescale 1ns/1ps
module spf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Control side.
  spf_fifo_if.mem  f
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          do_push;
  logic          do_pop;

  // Full follows the mode capacity, not the physical depth.
  assign f.full  = cnt_r >= f.cap;
  assign f.empty = cnt_r == '0;
  assign f.count = cnt_r;
  assign f.head  = mem_r[rp_r];
  assign do_push = f.push & ~f.full & ~f.clear;
  assign do_pop  = f.pop & ~f.empty & ~f.clear;

  // Storage needs no reset; only pointers define its content.
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wp_r] <= f.wdata;
    end
  end

  // Clear wins over push and pop in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (f.clear) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(do_push);
      rp_r  <= rp_r + AW'(do_pop);
      cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

// file: verif/spf_shift_model.sv
`timescale 1ns/1ps
module spf_shift_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Transmit side.
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       hold,
  output logic            tx_take,
  output logic [7:0]      last_tx,
  // Receive side.
  input  wire logic       rx_go,
  input  wire logic [7:0] rx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  // A staged byte is taken one cycle after it shows; hold is a busy shifter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_take <= 1'b0;
      last_tx <= 8'h00;
    end else begin
      tx_take <= tx_valid && !hold && !tx_take;
      if (tx_take && tx_valid) last_tx <= tx_data;
    end
  end

  // Between bytes the data line flips, so stale data never looks valid.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= rx_go;
      rx_data  <= rx_go ? rx_byte : ~rx_data;
    end
  end
endmodule

// file: verif/serial_port_fifo_control_test.sv
`timescale 1ns/1ps
module serial_port_fifo_control_test;
  logic        clk = 1'b0, rst_b = 1'b0, hold = 1'b0, rx_go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx_valid, tx_take, rx_valid, irq;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx_byte = 8'h00;
  logic [7:0]  tx_data, rx_data, last_tx;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rr, wresp;
  int          n_errors = 0;
  int          cmp_count = 0;

  // Free-running clock at 100 MHz.
  always #5 clk = ~clk;

  spf_ctrl #(.DEPTH(4), .ADDR_W(8)) dut (
    .CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_TAKE(tx_take),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .IRQ(irq));

  spf_shift_model model (
    .clk(clk), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
    .hold(hold), .tx_take(tx_take), .last_tx(last_tx), .rx_go(rx_go),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_data(rx_data));

  // Prints the counts and the verdict, then stops the run.
  task wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that runs out of cycles counts as a mismatch.
  task tmo;
    n_errors++;
    $display("Wait limit reached at %0t", $time);
    wrap_up;
  endtask

  // Bus write: both channels offered together, each dropped when taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) tmo;
    wresp = bresp;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) tmo;
    d = rdata;
    rr = rresp;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask

  task setup(input logic [31:0] ctl);
    wr(8'h10, ctl | 32'h8);
    wr(8'h04, 32'h80);
  endtask

  task wait_idle;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (!tx_valid) break;
    end
    if (i == 100) tmo;
  endtask

  task t_reset;
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h0c, 32'h80);
    rchk(8'h1c, 32'h0);
    chk(rr, 2'h2);
    wr(8'h1c, 32'hff);
    chk(wresp, 2'h2);
    // A write with lane 0 off is answered but changes nothing.
    wstrb <= 4'h0;
    wr(8'h04, 32'h43);
    wstrb <= 4'hf;
    chk(wresp, 2'h0);
    rchk(8'h04, 32'h0);
    $display("Test reset done");
  endtask

  task t_rx(input logic [31:0] ctl, input int n, input logic [31:0] st);
    int i;
    setup(ctl);
    for (i = 0; i < n; i++) begin
      rx_go <= 1'b1;
      rx_byte <= 8'ha0 + 8'(i);
      @(posedge clk);
    end
    rx_go <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(8'h08, st);
    rchk(8'h00, 32'ha0);
    rchk(8'h08, st - 32'h81);
    wr(8'h10, ctl | 32'h8);
    rchk(8'h08, 32'h0);
    $display("Test receive done");
  endtask

  task t_tx;
    setup(32'h1);
    hold <= 1'b1;
    wr(8'h00, 32'h11);
    wr(8'h00, 32'h22);
    wr(8'h00, 32'h33);
    rchk(8'h0c, 32'h02);
    wr(8'h04, 32'hffffffbc);
    rchk(8'h0c, 32'h00);
    rchk(8'h04, 32'h00);
    hold <= 1'b0;
    wait_idle;
    $display("Test transmit clear done");
  endtask

  task t_irq(input logic [31:0] ctl, input logic [31:0] cfg, input int n,
             input logic exp);
    int i;
    wr(8'h10, 32'h0);
    setup(ctl);
    wr(8'h18, 32'h1);
    wr(8'h04, cfg);
    wr(8'h14, 32'h7);
    hold <= 1'b1;
    for (i = 0; i < n; i++) wr(8'h00, 32'h50 + 32'(i));
    hold <= 1'b0;
    wait_idle;
    rchk(8'h14, {29'h0, 2'b10, exp});
    chk(irq, exp);
    rchk(8'h0c, 32'h80);
    chk(last_tx, 8'h4f + 8'(n));
    wr(8'h14, 32'h1);
    @(posedge clk);
    chk(irq, 1'b0);
    $display("Test interrupt done");
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_rx(32'h1, 5, 32'h84);
    t_rx(32'h3, 3, 32'h82);
    t_rx(32'h5, 2, 32'h81);
    t_tx;
    t_irq(32'h1, 32'h01, 3, 1'b1);
    t_irq(32'h1, 32'h03, 3, 1'b0);
    t_irq(32'h1, 32'h43, 1, 1'b1);
    t_irq(32'h1, 32'h00, 1, 1'b1);
    t_irq(32'h3, 32'h02, 1, 1'b1);
    t_irq(32'h3, 32'h03, 3, 1'b1);
    wrap_up;
  end
endmodule
